// >>> include/smmnc_pkg.sv
// Package with constants and types for the management-mode nesting and halt control.
package smmnc_pkg;
  localparam int SMMNC_IF_BIT = 9;
  localparam int SMMNC_NMI_EN_BIT = 1;
  localparam int SMMNC_NEST_BIT = 6;
  localparam int SMMNC_SUSPEND_ON_HALT_BIT = 3;
  localparam logic [7:0] SMMNC_IDX_CTRL_TWO = 8'hC2;
  localparam logic [7:0] SMMNC_IDX_CTRL_THREE = 8'hC3;
  localparam logic [7:0] SMMNC_IDX_CTRL_FOUR = 8'hE8;
  localparam logic [31:0] SMMNC_CR0_RESET = 32'h00000010;
  localparam logic [31:0] SMMNC_EFLAGS_RESET = 32'h00000002;
  localparam logic [31:0] SMMNC_DR7_RESET = 32'h00000400;
  localparam logic [31:0] SMMNC_CS_LIMIT_4GB = 32'hFFFFFFFF;
  localparam logic [15:0] SMMNC_IDT_LIMIT_MIN = 16'h000F;
  localparam logic [31:0] SMMNC_SP_MIN = 32'h00000005;
  localparam logic SMMNC_NEST_RESET = 1'b1;
  typedef enum {SMMNC_RUN, SMMNC_SAVE, SMMNC_HALT, SMMNC_SUSPEND, SMMNC_SHUTDOWN} smmnc_state_t;
endpackage : smmnc_pkg

// >>> include/smmnc_pend_if.sv
// Interface carrying pending-event requests between the control core and the latch module.
`timescale 1ns/1ns
interface smmnc_pend_if;
  logic latch_en;
  logic intr_en;
  logic smi_en;
  logic nmi_in;
  logic intr_in;
  logic smi_in;
  logic nmi_take;
  logic intr_take;
  logic smi_take;
  logic nmi_pend;
  logic intr_pend;
  logic smi_pend;
  modport core (output latch_en, intr_en, smi_en, nmi_in, intr_in, smi_in,
                output nmi_take, intr_take, smi_take, input nmi_pend, intr_pend, smi_pend);
  modport latch (input latch_en, intr_en, smi_en, nmi_in, intr_in, smi_in,
                 input nmi_take, intr_take, smi_take, output nmi_pend, intr_pend, smi_pend);
endinterface : smmnc_pend_if

// >>> core/smmnc_pend_latch.sv
// Single-occurrence latches for held-off NMI, INTR and external management interrupts.
`timescale 1ns/1ns
module smmnc_pend_latch
  import smmnc_pkg::*;
(
  input wire clk,
  input wire rst_n,
  smmnc_pend_if.latch p
);
  logic [2:0] ev;
  logic [2:0] en;
  logic [2:0] take;
  logic [2:0] pend;

  // Collect the three event lanes so one loop handles them all.
  assign ev = {p.smi_in, p.intr_in, p.nmi_in};
  assign en = {p.smi_en, p.latch_en & p.intr_en, p.latch_en};
  assign take = {p.smi_take, p.intr_take, p.nmi_take};
  assign p.nmi_pend = pend[0];
  assign p.intr_pend = pend[1];
  assign p.smi_pend = pend[2];

  // Each lane holds one occurrence; a new event in the take cycle wins over the clear.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lane
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          pend[g] <= 1'b0;
        else if (ev[g] && en[g])
          pend[g] <= 1'b1;
        else if (take[g])
          pend[g] <= 1'b0;
      end
    end
  endgenerate

  a_one_pending: assert property (@(posedge clk) disable iff (!rst_n)
    (p.smi_in && p.smi_en) |=> p.smi_pend)
    else $error("held external request was not recorded");
endmodule : smmnc_pend_latch

// >>> core/smmnc_ctrl.sv
// Management-mode entry, nesting, suspend, halt and shutdown control for the core.
// Contract
// - After header save, CR0, EFLAGS and DR7 return to reset values.
// - Entry loads code base from region register, 4 GB limit, real mode.
// - Entry clears interrupt flag bit 9; software may set it again.
// - NMI in management mode only if enabled; else latch one for later.
// - Resume restores state from header, picks real or protected mode.
// - Nested management interrupt taken only when enable_a is high.
// - Taking an interrupt clears enable_a, saves nested status, sets it.
// - Resume sets enable_a, reloads nested status; one stays in mode.
// - Outside management mode nested status is zero and enable_a high.
// - External request held while nesting off, taken at once when on.
// - Internal requests inside management mode are ignored.
// - Simultaneous internal and external: internal first, external kept.
// - In management mode, HLT or suspend request pin enters Suspend.
// - In pin Suspend, NMI and enabled INTR latch for later; mode Suspend services them.
// - Suspend by HLT in normal code ends on a management interrupt.
// - Pin Suspend in normal code latches one INTR, NMI and interrupt.
// - HLT issues Halt cycle; with suspend_on_halt, Stop Grant and Suspend.
// - Halt ends on interrupt, NMI, enabled INTR or reset; return after HLT.
// - Fault during double fault enters shutdown; reset always leaves it.
// - NMI leaves shutdown only if IDT limit >= 000Fh and SP > 0005h.
// - Hardware request during software entry waits for resume.
`timescale 1ns/1ns
module smmnc_ctrl
  import smmnc_pkg::*;
(
  input wire clk,
  input wire rst_n,
  input wire sys_mgmt_interrupt_n,
  input wire suspend_request_n,
  input wire nmi,
  input wire intr,
  input wire smi_internal,
  input wire smint_exec,
  input wire hlt_exec,
  input wire rsm_exec,
  input wire triple_fault,
  input wire save_done,
  input wire [31:0] smm_region_base,
  input wire [15:0] idt_limit,
  input wire [31:0] stack_ptr,
  input wire [7:0] cfg_index,
  input wire [7:0] cfg_wdata,
  input wire cfg_we,
  input wire eflags_if_write,
  input wire eflags_if_value,
  input wire hdr_nested,
  input wire hdr_protected,
  output logic sys_mgmt_mode,
  output logic enable_a,
  output logic nested_smi_status,
  output logic hdr_nested_wr,
  output logic hdr_save_req,
  output logic load_reset_regs,
  output logic [31:0] cr0_value,
  output logic [31:0] eflags_value,
  output logic [31:0] dr7_value,
  output logic [31:0] cs_base,
  output logic [31:0] cs_limit,
  output logic real_mode,
  output logic fetch_start,
  output logic return_after_hlt,
  output logic halt_cycle,
  output logic stop_grant_cycle,
  output logic suspended,
  output logic shutdown,
  output logic nmi_service,
  output logic intr_service,
  output logic [7:0] cfg_rdata
);
  smmnc_state_t state;
  logic smi_s1, smi_s2, suspend_request_n_s1, suspend_request_n_s2, nmi_s1, nmi_s2, intr_s1, intr_s2;
  logic smi_prev, nmi_prev;
  logic smi_edge, nmi_edge, suspend_request_n_pin;
  logic nmi_in_smm_enable, suspend_on_halt, eflags_if;
  logic sw_entry, suspend_request_n_by_pin, hold_nmi_smi;
  logic take_int, take_ext, take_smi, ext_allowed, exit_out;
  smmnc_pend_if pif ();

  smmnc_pend_latch u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .p(pif.latch)
  );

  // Pins come from outside the clock domain and pass two flip-flops first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {smi_s1, smi_s2, suspend_request_n_s1, suspend_request_n_s2} <= 4'hF;
      {nmi_s1, nmi_s2, intr_s1, intr_s2} <= 4'h0;
      smi_prev <= 1'b0;
      nmi_prev <= 1'b0;
    end
    else
    begin
      smi_s1 <= sys_mgmt_interrupt_n;
      smi_s2 <= smi_s1;
      suspend_request_n_s1 <= suspend_request_n;
      suspend_request_n_s2 <= suspend_request_n_s1;
      nmi_s1 <= nmi;
      nmi_s2 <= nmi_s1;
      intr_s1 <= intr;
      intr_s2 <= intr_s1;
      smi_prev <= !smi_s2;
      nmi_prev <= nmi_s2;
    end
  end

  assign smi_edge = !smi_s2 && !smi_prev;
  assign nmi_edge = nmi_s2 && !nmi_prev;
  assign suspend_request_n_pin = !suspend_request_n_s2;

  // Configuration bits written through the index port.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_in_smm_enable <= 1'b0;
      suspend_on_halt <= 1'b0;
    end
    else if (cfg_we)
    begin
      if (cfg_index == SMMNC_IDX_CTRL_THREE)
        nmi_in_smm_enable <= cfg_wdata[SMMNC_NMI_EN_BIT];
      if (cfg_index == SMMNC_IDX_CTRL_TWO)
        suspend_on_halt <= cfg_wdata[SMMNC_SUSPEND_ON_HALT_BIT];
    end
  end

  // Read back of configuration, including the live nesting bit.
  always_comb
  begin
    cfg_rdata = 8'h00;
    case (cfg_index)
      SMMNC_IDX_CTRL_TWO: cfg_rdata[SMMNC_SUSPEND_ON_HALT_BIT] = suspend_on_halt;
      SMMNC_IDX_CTRL_THREE: cfg_rdata[SMMNC_NMI_EN_BIT] = nmi_in_smm_enable;
      SMMNC_IDX_CTRL_FOUR: cfg_rdata[SMMNC_NEST_BIT] = enable_a;
      default: cfg_rdata = 8'h00;
    endcase
  end

  // Request arbitration: internal wins, external waits in the pending flag.
  assign ext_allowed = !sys_mgmt_mode || (enable_a && !sw_entry);
  assign take_int = smi_internal && !sys_mgmt_mode && state == SMMNC_RUN;
  assign take_ext = pif.smi_pend && ext_allowed && !take_int && !hold_nmi_smi
                    && (state == SMMNC_RUN || (state == SMMNC_HALT && !suspend_request_n_by_pin)
                    || (state == SMMNC_SUSPEND && !suspend_request_n_by_pin));
  assign take_smi = take_int || take_ext || (smint_exec && state == SMMNC_RUN);
  assign exit_out = rsm_exec && sys_mgmt_mode && !hdr_nested;
  assign hold_nmi_smi = suspend_request_n_by_pin && state == SMMNC_SUSPEND;

  // Event latches: external requests always recorded; NMI and INTR held off.
  assign pif.smi_in = smi_edge;
  assign pif.smi_en = 1'b1;
  assign pif.nmi_in = nmi_edge;
  assign pif.intr_in = intr_s2;
  assign pif.latch_en = 1'b1;
  assign pif.intr_en = eflags_if;
  assign pif.smi_take = take_ext;
  assign nmi_service = pif.nmi_pend && !hold_nmi_smi && state != SMMNC_SAVE
                       && (!sys_mgmt_mode || nmi_in_smm_enable)
                       && (state != SMMNC_SHUTDOWN || (idt_limit >= SMMNC_IDT_LIMIT_MIN
                       && stack_ptr > SMMNC_SP_MIN));
  assign intr_service = pif.intr_pend && eflags_if && !hold_nmi_smi
                        && state != SMMNC_SAVE && state != SMMNC_SHUTDOWN;
  assign pif.nmi_take = nmi_service;
  assign pif.intr_take = intr_service;

  // Main state sequence for entry, halt, suspend and shutdown.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SMMNC_RUN;
    else
      case (state)
        SMMNC_RUN:
          if (triple_fault)
            state <= SMMNC_SHUTDOWN;
          else if (take_smi)
            state <= SMMNC_SAVE;
          else if (hlt_exec)
            state <= (suspend_on_halt || sys_mgmt_mode) ? SMMNC_SUSPEND : SMMNC_HALT;
          else if (suspend_request_n_pin)
            state <= SMMNC_SUSPEND;
        SMMNC_SAVE:
          if (save_done)
            state <= SMMNC_RUN;
        SMMNC_HALT, SMMNC_SUSPEND:
          if (take_smi)
            state <= SMMNC_SAVE;
          else if ((suspend_request_n_by_pin && !suspend_request_n_pin) || (!suspend_request_n_by_pin && (nmi_service || intr_service)))
            state <= SMMNC_RUN;
        SMMNC_SHUTDOWN:
          if (nmi_service)
            state <= SMMNC_RUN;
        default: state <= SMMNC_RUN;
      endcase
  end

  // Suspend origin bookkeeping.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      suspend_request_n_by_pin <= 1'b0;
    end
    else if (state == SMMNC_RUN && !take_smi && !triple_fault)
    begin
      suspend_request_n_by_pin <= !hlt_exec && suspend_request_n_pin;
    end
  end

  // Mode, nesting bit and nested status.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_mgmt_mode <= 1'b0;
      enable_a <= SMMNC_NEST_RESET;
      nested_smi_status <= 1'b0;
      hdr_nested_wr <= 1'b0;
      sw_entry <= 1'b0;
    end
    else if (take_smi)
    begin
      hdr_nested_wr <= nested_smi_status;
      nested_smi_status <= 1'b1;
      enable_a <= 1'b0;
      sys_mgmt_mode <= 1'b1;
      sw_entry <= smint_exec && !take_int && !take_ext;
    end
    else if (rsm_exec && sys_mgmt_mode)
    begin
      enable_a <= 1'b1;
      nested_smi_status <= hdr_nested;
      sys_mgmt_mode <= hdr_nested;
      if (!hdr_nested)
        sw_entry <= 1'b0;
    end
    else if (cfg_we && cfg_index == SMMNC_IDX_CTRL_FOUR && sys_mgmt_mode)
      enable_a <= cfg_wdata[SMMNC_NEST_BIT];
  end

  // Register reload on entry and restore on resume.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cr0_value <= SMMNC_CR0_RESET;
      eflags_value <= SMMNC_EFLAGS_RESET;
      dr7_value <= SMMNC_DR7_RESET;
      cs_base <= 32'h00000000;
      cs_limit <= SMMNC_CS_LIMIT_4GB;
      real_mode <= 1'b1;
      load_reset_regs <= 1'b0;
      fetch_start <= 1'b0;
    end
    else
    begin
      load_reset_regs <= state == SMMNC_SAVE && save_done;
      fetch_start <= state == SMMNC_SAVE && save_done;
      if (state == SMMNC_SAVE && save_done)
      begin
        cr0_value <= SMMNC_CR0_RESET;
        eflags_value <= SMMNC_EFLAGS_RESET;
        dr7_value <= SMMNC_DR7_RESET;
        cs_base <= smm_region_base;
        cs_limit <= SMMNC_CS_LIMIT_4GB;
        real_mode <= 1'b1;
      end
      else if (exit_out)
        real_mode <= !hdr_protected;
      else if (eflags_if_write)
        eflags_value[SMMNC_IF_BIT] <= eflags_if_value;
    end
  end

  assign eflags_if = eflags_value[SMMNC_IF_BIT];
  assign hdr_save_req = state == SMMNC_SAVE;
  assign suspended = state == SMMNC_SUSPEND;
  assign shutdown = state == SMMNC_SHUTDOWN;

  // Bus-cycle pulses and halt return point marker.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_cycle <= 1'b0;
      stop_grant_cycle <= 1'b0;
      return_after_hlt <= 1'b0;
    end
    else
    begin
      halt_cycle <= state == SMMNC_RUN && hlt_exec && !take_smi && !triple_fault;
      stop_grant_cycle <= state == SMMNC_RUN && !take_smi && !triple_fault
                          && ((hlt_exec && (suspend_on_halt || sys_mgmt_mode)) || suspend_request_n_pin);
      if (state == SMMNC_RUN && hlt_exec)
        return_after_hlt <= 1'b1;
      else if (state == SMMNC_RUN)
        return_after_hlt <= 1'b0;
    end
  end

  a_outside_bits: assert property (@(posedge clk) disable iff (!rst_n)
    !sys_mgmt_mode |-> (enable_a && !nested_smi_status))
    else $error("nesting bits wrong outside management mode");
  a_take_clears_nest: assert property (@(posedge clk) disable iff (!rst_n)
    take_smi |=> (!enable_a && nested_smi_status && hdr_nested_wr == $past(nested_smi_status)))
    else $error("entry did not update nesting bits");
  a_resume_sets_nest: assert property (@(posedge clk) disable iff (!rst_n)
    (rsm_exec && sys_mgmt_mode && !take_smi) |=> (enable_a && sys_mgmt_mode == $past(hdr_nested)))
    else $error("resume did not restore nesting");
  a_entry_regs: assert property (@(posedge clk) disable iff (!rst_n)
    (state == SMMNC_SAVE && save_done) |=> (cr0_value == SMMNC_CR0_RESET
    && !eflags_if && cs_limit == SMMNC_CS_LIMIT_4GB && real_mode))
    else $error("entry registers not reset");
  a_nest_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_mgmt_mode && !enable_a) |-> !take_ext)
    else $error("external request taken while nesting off");
  a_internal_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    sys_mgmt_mode |-> !take_int)
    else $error("internal request taken in management mode");
  a_nmi_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_mgmt_mode && !nmi_in_smm_enable) |-> !nmi_service)
    else $error("NMI serviced while disabled");
  a_shutdown_enter: assert property (@(posedge clk) disable iff (!rst_n)
    (state == SMMNC_RUN && triple_fault) |=> shutdown)
    else $error("triple fault did not shut down");
  a_priority: assert property (@(posedge clk) disable iff (!rst_n)
    (take_int && pif.smi_pend) |=> pif.smi_pend)
    else $error("external request lost under internal priority");
  a_halt_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    (state == SMMNC_RUN && hlt_exec && !take_smi && !triple_fault) |=> halt_cycle)
    else $error("no halt cycle after HLT");

  c_nested_entry: cover property (@(posedge clk) disable iff (!rst_n) take_ext && sys_mgmt_mode);
  c_halt_wake: cover property (@(posedge clk) disable iff (!rst_n) state == SMMNC_HALT ##1 state == SMMNC_SAVE);
  c_pin_suspend: cover property (@(posedge clk) disable iff (!rst_n) suspended && suspend_request_n_by_pin);
  c_shutdown_exit: cover property (@(posedge clk) disable iff (!rst_n) shutdown ##1 !shutdown);
endmodule : smmnc_ctrl

// >>> testbench/smmnc_chipset_model.sv
// Model of the chipset that drives the management, suspend, NMI and INTR pins.
`timescale 1ns/1ns
module smmnc_chipset_model
(
  input wire clk,
  input wire slow,
  input wire [3:0] req,
  output logic sys_mgmt_interrupt_n,
  output logic suspend_request_n,
  output logic nmi,
  output logic intr
);
  logic [3:0] stage;
  logic [3:0] lag;
  // Both request pins idle high and the edge pins idle low before the first edge.
  initial
  begin
    sys_mgmt_interrupt_n = 1'b1;
    suspend_request_n = 1'b1;
    nmi = 1'b0;
    intr = 1'b0;
  end
  // Requests are taken at the rising edge; a slow answer adds one more cycle.
  always @(posedge clk)
  begin
    stage <= req;
    lag <= stage;
  end
  // Pins change just after the falling edge and hold until the next request change.
  always @(negedge clk)
  begin
    sys_mgmt_interrupt_n <= ~(slow ? lag[3] : stage[3]);
    suspend_request_n <= ~(slow ? lag[2] : stage[2]);
    nmi <= slow ? lag[1] : stage[1];
    intr <= slow ? lag[0] : stage[0];
  end
endmodule : smmnc_chipset_model

// >>> testbench/smm_nesting_halt_control_tb.sv
// Self-checking testbench for the management-mode nesting and halt control.
`timescale 1ns/1ns
module smm_nesting_halt_control_tb
  import smmnc_pkg::*;
;
  localparam logic [5:0] S_INT = 6'h20, S_SMINT = 6'h10, S_HLT = 6'h08;
  localparam logic [5:0] S_RSM = 6'h04, S_TRIP = 6'h02, S_SAVE = 6'h01;
  logic clk, rst_n, smi_internal, smint_exec, hlt_exec, rsm_exec, triple_fault, save_done;
  logic cfg_we, eflags_if_write, eflags_if_value, hdr_nested, hdr_protected, slow;
  logic sys_mgmt_interrupt_n, suspend_request_n, nmi, intr, save_was;
  logic [3:0] req;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
  logic [15:0] idt_limit;
  logic [31:0] smm_region_base, stack_ptr, cr0_value, eflags_value, dr7_value, cs_base, cs_limit;
  logic sys_mgmt_mode, enable_a, nested_smi_status, hdr_nested_wr, hdr_save_req;
  logic load_reset_regs, real_mode, fetch_start, return_after_hlt, halt_cycle;
  logic stop_grant_cycle, suspended, shutdown, nmi_service, intr_service;
  int err_total, comparisons, nmi_cnt, intr_cnt, take_cnt, halt_cnt, sg_cnt, fetch_cnt, n0;
  int load_cnt;

  smmnc_chipset_model i_smmnc_chipset_model (.clk, .slow, .req, .sys_mgmt_interrupt_n,
    .suspend_request_n, .nmi, .intr);
  smmnc_ctrl i_smmnc_ctrl (.clk, .rst_n, .sys_mgmt_interrupt_n, .suspend_request_n, .nmi,
    .intr, .smi_internal, .smint_exec, .hlt_exec, .rsm_exec, .triple_fault, .save_done,
    .smm_region_base, .idt_limit, .stack_ptr, .cfg_index, .cfg_wdata, .cfg_we,
    .eflags_if_write, .eflags_if_value, .hdr_nested, .hdr_protected, .sys_mgmt_mode,
    .enable_a, .nested_smi_status, .hdr_nested_wr, .hdr_save_req, .load_reset_regs,
    .cr0_value, .eflags_value, .dr7_value, .cs_base, .cs_limit, .real_mode, .fetch_start,
    .return_after_hlt, .halt_cycle, .stop_grant_cycle, .suspended, .shutdown,
    .nmi_service, .intr_service, .cfg_rdata);

  // Clock of 10 ns period.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count one-cycle pulses and new header saves, so short pulses are never missed.
  always @(posedge clk)
  begin
    nmi_cnt <= nmi_cnt + (nmi_service === 1'b1);
    intr_cnt <= intr_cnt + (intr_service === 1'b1);
    halt_cnt <= halt_cnt + (halt_cycle === 1'b1);
    sg_cnt <= sg_cnt + (stop_grant_cycle === 1'b1);
    fetch_cnt <= fetch_cnt + (fetch_start === 1'b1);
    load_cnt <= load_cnt + (load_reset_regs === 1'b1);
    take_cnt <= take_cnt + (hdr_save_req === 1'b1 && save_was !== 1'b1);
    save_was <= hdr_save_req;
  end

  // Compares a seen value with the expected one and reports a mismatch at once.
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits a number of falling edges.
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Raises the selected core pulses for exactly one cycle.
  task strobe(input logic [5:0] sel);
    @(negedge clk);
    {smi_internal, smint_exec, hlt_exec, rsm_exec, triple_fault, save_done} = sel;
    @(negedge clk);
    {smi_internal, smint_exec, hlt_exec, rsm_exec, triple_fault, save_done} = 6'h00;
  endtask : strobe

  // Writes one configuration index for one cycle.
  task cfg_write(input logic [7:0] idx, input logic [7:0] val);
    @(negedge clk);
    cfg_index = idx;
    cfg_wdata = val;
    cfg_we = 1'b1;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask : cfg_write

  // Asks the chipset to hold the given pins for four cycles, then release them.
  task pins(input logic [3:0] r);
    req = r;
    idle(4);
    req = 4'h0;
    idle(4);
  endtask : pins

  // Waits, with a bound, until the mode output reaches the wanted level.
  // One more cycle follows so that the entry counter has seen the new save.
  task wait_mode(input logic exp);
    int n;
    for (n = 0; n < 12 && sys_mgmt_mode !== exp; n++)
      @(negedge clk);
    @(negedge clk);
  endtask : wait_mode

  // Handler exit: clear nesting, restore the header, then resume.
  task leave(input logic nest);
    hdr_nested = nest;
    cfg_write(SMMNC_IDX_CTRL_FOUR, 8'h00);
    strobe(S_RSM);
    idle(1);
  endtask : leave

  task done(input string s);
    $display("test %s finished", s);
  endtask : done

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Watchdog far beyond the few hundred cycles the tests need.
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end

  // Main test sequence.
  initial
  begin
    rst_n = 1'b0;
    {smi_internal, smint_exec, hlt_exec, rsm_exec, triple_fault, save_done} = 6'h00;
    {cfg_we, eflags_if_write, eflags_if_value, hdr_nested, hdr_protected, slow} = 6'h00;
    {req, cfg_index, cfg_wdata, idt_limit, stack_ptr} = '0;
    smm_region_base = 32'h000A0000;
    idle(5);
    rst_n = 1'b1;
    idle(1);
    check(sys_mgmt_mode, 1'b0);
    check({enable_a, nested_smi_status}, 2'h2);
    done("reset");

    strobe(S_SMINT);
    check({sys_mgmt_mode, enable_a, nested_smi_status, hdr_save_req}, 4'hB);
    check(hdr_nested_wr, 1'b0);
    strobe(S_SAVE);
    idle(2);
    check(fetch_cnt, 1);
    check(load_cnt, 1);
    check({cr0_value, dr7_value}, {SMMNC_CR0_RESET, SMMNC_DR7_RESET});
    check(eflags_value, SMMNC_EFLAGS_RESET);
    check(eflags_value[SMMNC_IF_BIT], 1'b0);
    check({cs_base, cs_limit}, {32'h000A0000, SMMNC_CS_LIMIT_4GB});
    check(real_mode, 1'b1);
    done("entry");

    pins(4'h2);
    check(nmi_cnt, 0);
    cfg_write(SMMNC_IDX_CTRL_THREE, 8'h02);
    idle(3);
    check(nmi_cnt, 1);
    check(cfg_rdata[SMMNC_NMI_EN_BIT], 1'b1);
    done("nmi hold");

    cfg_write(SMMNC_IDX_CTRL_FOUR, 8'h40);
    idle(1);
    check(enable_a, 1'b1);
    pins(4'h8);
    check(take_cnt, 1);
    leave(1'b0);
    wait_mode(1'b1);
    check({sys_mgmt_mode, 32'(take_cnt)}, {1'b1, 32'd2});
    strobe(S_SAVE);
    cfg_write(SMMNC_IDX_CTRL_FOUR, 8'h40);
    pins(4'h8);
    check(take_cnt, 3);
    check({enable_a, nested_smi_status, hdr_nested_wr}, 3'h3);
    strobe(S_SAVE);
    leave(1'b1);
    check({sys_mgmt_mode, enable_a, nested_smi_status}, 3'h7);
    hdr_protected = 1'b1;
    leave(1'b0);
    check({sys_mgmt_mode, enable_a, nested_smi_status}, 3'h2);
    check(real_mode, 1'b0);
    hdr_protected = 1'b0;
    done("nesting");

    req = 4'h8;
    idle(3);
    strobe(S_INT);
    req = 4'h0;
    strobe(S_SAVE);
    pins(4'h8);
    pins(4'h8);
    strobe(S_INT);
    idle(4);
    check(take_cnt, 4);
    leave(1'b0);
    wait_mode(1'b1);
    check(take_cnt, 5);
    strobe(S_SAVE);
    leave(1'b0);
    idle(8);
    check({sys_mgmt_mode, 32'(take_cnt)}, {1'b0, 32'd5});
    done("held requests");

    cfg_write(SMMNC_IDX_CTRL_TWO, 8'h08);
    strobe(S_HLT);
    idle(3);
    check({32'(halt_cnt), 32'(sg_cnt)}, {32'd1, 32'd1});
    check(suspended, 1'b1);
    pins(4'h8);
    wait_mode(1'b1);
    check(sys_mgmt_mode, 1'b1);
    check(return_after_hlt, 1'b1);
    strobe(S_SAVE);
    leave(1'b0);
    cfg_write(SMMNC_IDX_CTRL_TWO, 8'h00);
    eflags_if_write = 1'b1;
    eflags_if_value = 1'b1;
    idle(1);
    eflags_if_write = 1'b0;
    strobe(S_HLT);
    idle(3);
    check({32'(halt_cnt), 32'(sg_cnt)}, {32'd2, 32'd1});
    req = 4'h1;
    idle(6);
    req = 4'h0;
    check(intr_cnt != 0, 1'b1);
    done("halt");

    slow = 1'b1;
    n0 = nmi_cnt;
    req = 4'h4;
    idle(6);
    check(suspended, 1'b1);
    req = 4'h6;
    idle(4);
    req = 4'hC;
    idle(4);
    req = 4'h4;
    idle(4);
    check({sys_mgmt_mode, 32'(nmi_cnt)}, {1'b0, 32'(n0)});
    req = 4'h0;
    wait_mode(1'b1);
    idle(4);
    check({sys_mgmt_mode, 32'(nmi_cnt)}, {1'b1, 32'(n0 + 1)});
    strobe(S_SAVE);
    leave(1'b0);
    slow = 1'b0;
    done("pin suspend");

    strobe(S_TRIP);
    idle(1);
    check(shutdown, 1'b1);
    idt_limit = 16'h000E;
    stack_ptr = 32'h00000006;
    pins(4'h2);
    check(shutdown, 1'b1);
    idt_limit = 16'h000F;
    stack_ptr = 32'h00000005;
    pins(4'h2);
    check(shutdown, 1'b1);
    stack_ptr = 32'h00000006;
    pins(4'h2);
    check(shutdown, 1'b0);
    strobe(S_TRIP);
    idle(1);
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(1);
    check({shutdown, sys_mgmt_mode, enable_a, nested_smi_status}, 4'h2);
    done("shutdown");
    conclude();
  end
endmodule : smm_nesting_halt_control_tb
